// File: shared/t16_defs.vh
// register offsets, field positions, reset values and codes of the 16-bit timer
`ifndef T16_DEFS_VH
`define T16_DEFS_VH
`define T16_OFS_CTRL_A        8'h00
`define T16_OFS_CTRL_B        8'h04
`define T16_OFS_CTRL_C        8'h08
`define T16_OFS_CTRL_D        8'h0C
`define T16_OFS_CNT_L         8'h10
`define T16_OFS_CNT_H         8'h14
`define T16_OFS_CMPA_L        8'h18
`define T16_OFS_CMPA_H        8'h1C
`define T16_OFS_CMPB_L        8'h20
`define T16_OFS_CMPB_H        8'h24
`define T16_OFS_CAPT_L        8'h28
`define T16_OFS_CAPT_H        8'h2C
`define T16_OFS_MASK          8'h30
`define T16_OFS_FLAGS         8'h34
`define T16_RST_BYTE          8'h00
`define T16_RST_WORD          16'h0000
`define T16_CTRL_B_RMASK      8'hDF
`define T16_MASK_RMASK        8'h27
`define T16_BIT_FILT          7
`define T16_BIT_EDGE          6
`define T16_BIT_FORCE_A       7
`define T16_BIT_FORCE_B       6
`define T16_BIT_CAPT          5
`define T16_BIT_CMPB          2
`define T16_BIT_CMPA          1
`define T16_BIT_OVF           0
`define T16_FILT_SAMPLES      4
`define T16_TOP_MAX           16'hFFFF
`define T16_TOP_8BIT          16'h00FF
`define T16_TOP_9BIT          16'h01FF
`define T16_TOP_10BIT         16'h03FF
`define T16_CS_STOP           3'h0
`define T16_CS_DIV1           3'h1
`define T16_CS_DIV8           3'h2
`define T16_CS_DIV64          3'h3
`define T16_CS_DIV256         3'h4
`define T16_CS_DIV1024        3'h5
`define T16_CS_EXT_FALL       3'h6
`define T16_CS_EXT_RISE       3'h7
`define T16_COM_OFF           2'h0
`define T16_COM_TOGGLE        2'h1
`define T16_COM_CLEAR         2'h2
`define T16_COM_SET           2'h3
`endif

// File: hdl/t16_timer.v
// 16-bit timer/counter with input capture, two compare channels and an AHB-Lite register slave
//
// Overview of operation
// - filter passes capture after four equal samples
// - filtered capture detected four cycles later
// - edge select: zero falling, one rising
// - capture copies counter, sets capture flag
// - capture pin ignored while capture is top
// - clock select: stop, prescales, external edges
// - external pin counted even when driven out
// - force strobe acts as match, non-PWM only
// - force raises no interrupt, no counter clear
// - force bits always read zero
// - upper nibble enables B pins, lower A
// - shared temporary high byte for 16-bit access
// - counter write blocks next compare match
// - compare registers continuously compared with counter
// - mask bits and global flag gate interrupts
// - capture-as-top sets capture flag at top
// - match flag set timer cycle after equality
// - force does not set match flag
// - flags clear on vector or written one
// - overflow flag set per waveform mode
// - waveform mode selects sequence and top
// - compare output mode acts on enabled pins
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
`include "t16_defs.vh"
module t16_timer (
  input  wire        hclk,                // bus and timer clock
  input  wire        hresetn,             // asynchronous reset, active low
  input  wire        hsel,                // slave select
  input  wire [31:0] haddr,               // byte address
  input  wire [1:0]  htrans,              // transfer type
  input  wire        hwrite,              // write when high
  input  wire [2:0]  hsize,               // transfer size
  input  wire [31:0] hwdata,              // write data
  input  wire        hready,              // bus ready
  output reg  [31:0] hrdata,              // read data
  output wire        hreadyout,           // slave ready
  output wire        hresp,               // always okay
  input  wire        capture_pin,         // asynchronous capture input
  input  wire        external_clock_pin,  // asynchronous count input
  input  wire        global_irq_en,       // cpu global interrupt flag
  input  wire [3:0]  irq_vector_taken,    // pulses: capture, cmp b, cmp a, overflow
  output wire        irq_capture,         // capture interrupt request
  output wire        irq_compare_b,       // compare b interrupt request
  output wire        irq_compare_a,       // compare a interrupt request
  output wire        irq_overflow,        // overflow interrupt request
  output wire [3:0]  chan_a_pins,         // channel a pin levels
  output wire [3:0]  chan_a_pins_oe_n,    // channel a pin drive, low drives
  output wire [3:0]  chan_b_pins,         // channel b pin levels
  output wire [3:0]  chan_b_pins_oe_n     // channel b pin drive, low drives
);

  reg  [7:0]  timer_ctrl_a;
  reg  [7:0]  timer_ctrl_b;
  reg  [7:0]  timer_ctrl_d_pin_enable;
  reg  [15:0] counter_value;
  reg  [15:0] compare_a_value;
  reg  [15:0] compare_b_value;
  reg  [15:0] capture_value;
  reg  [7:0]  timer_irq_mask;
  reg  [7:0]  timer_irq_flags;
  reg  [7:0]  temp_high;
  reg         count_up;
  reg         match_block;
  reg         oc_a;
  reg         oc_b;
  reg  [9:0]  prescale;
  reg  [1:0]  capt_sync;
  reg  [1:0]  ext_sync;
  reg         ext_prev;
  reg  [3:0]  filt_shift;
  reg         filt_out;
  reg         capt_prev;
  // filter shift value after this edge, so the output can follow on the fourth equal sample
  wire [3:0]  next_filt_shift = {filt_shift[2:0], capt_sync[1]};
  reg         ap_write;
  reg  [7:0]  ap_addr;
  reg         rd_pend;
  reg         wr_pend;

  wire [3:0]  waveform_mode = {timer_ctrl_b[4:3], timer_ctrl_a[1:0]};
  wire [2:0]  clock_select  = timer_ctrl_b[2:0];
  wire [1:0]  com_a         = timer_ctrl_a[7:6];
  wire [1:0]  com_b         = timer_ctrl_a[5:4];
  wire [3:0]  chan_a_pin_enables = timer_ctrl_d_pin_enable[3:0];
  wire [3:0]  chan_b_pin_enables = timer_ctrl_d_pin_enable[7:4];
  wire [7:0]  wbyte         = hwdata[7:0];

  // waveform mode decode
  wire mode_ctc   = (waveform_mode == 4'h4) || (waveform_mode == 4'hC);
  wire mode_norm  = (waveform_mode == 4'h0) || (waveform_mode == 4'hD);
  wire mode_fast  = (waveform_mode == 4'h5) || (waveform_mode == 4'h6) || (waveform_mode == 4'h7) ||
                    (waveform_mode == 4'hE) || (waveform_mode == 4'hF);
  wire mode_phase = !mode_ctc && !mode_norm && !mode_fast;
  wire mode_pwm   = mode_fast || mode_phase;
  wire capt_top   = (waveform_mode == 4'h8) || (waveform_mode == 4'hA) ||
                    (waveform_mode == 4'hC) || (waveform_mode == 4'hE);
  reg  [15:0] top;
  always @* begin
    case (waveform_mode)
      4'h1, 4'h5: top = `T16_TOP_8BIT;
      4'h2, 4'h6: top = `T16_TOP_9BIT;
      4'h3, 4'h7: top = `T16_TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: top = compare_a_value;
      4'h8, 4'hA, 4'hC, 4'hE: top = capture_value;
      default: top = `T16_TOP_MAX;
    endcase
  end

  // clock selection
  wire ext_rise = ext_sync[1] && !ext_prev;
  wire ext_fall = !ext_sync[1] && ext_prev;
  reg  tick;
  always @* begin
    case (clock_select)
      `T16_CS_STOP:     tick = 1'b0;
      `T16_CS_DIV1:     tick = 1'b1;
      `T16_CS_DIV8:     tick = (prescale[2:0] == 3'h7);
      `T16_CS_DIV64:    tick = (prescale[5:0] == 6'h3F);
      `T16_CS_DIV256:   tick = (prescale[7:0] == 8'hFF);
      `T16_CS_DIV1024:  tick = (prescale == 10'h3FF);
      `T16_CS_EXT_FALL: tick = ext_fall;
      `T16_CS_EXT_RISE: tick = ext_rise;
      default:          tick = 1'b0;
    endcase
  end

  // compare and counter events, evaluated on the value before the tick
  wire at_top  = (counter_value == top);
  wire at_zero = (counter_value == `T16_RST_WORD);
  wire hit_a   = tick && !match_block && (counter_value == compare_a_value);
  wire hit_b   = tick && !match_block && (counter_value == compare_b_value);
  reg  ovf_evt;
  always @* begin
    if (mode_phase)
      ovf_evt = tick && at_zero && !count_up;
    else if (mode_fast)
      ovf_evt = tick && at_top;
    else
      ovf_evt = tick && (counter_value == `T16_TOP_MAX);
  end

  // capture source
  wire capt_sig  = timer_ctrl_b[`T16_BIT_FILT] ? filt_out : capt_sync[1];
  wire capt_edge = timer_ctrl_b[`T16_BIT_EDGE] ? (capt_sig && !capt_prev)
                                               : (!capt_sig && capt_prev);
  wire capt_evt  = capt_edge && !capt_top;
  wire capt_flag_set = capt_evt || (capt_top && tick && at_top);

  // bus
  // writes complete with no wait state: the data phase byte is applied at the
  // edge that ends the data phase; reads take one wait state so that hrdata is
  // loaded from a flop at the same edge at which hreadyout rises again.
  // the upper address bits must be zero, anything else maps to an unused offset
  wire ap_take = hsel && hready && htrans[1];
  wire do_wr   = wr_pend;
  wire do_rd   = rd_pend;
  wire force_a = do_wr && (ap_addr == `T16_OFS_CTRL_C) && wbyte[`T16_BIT_FORCE_A] && !mode_pwm;
  wire force_b = do_wr && (ap_addr == `T16_OFS_CTRL_C) && wbyte[`T16_BIT_FORCE_B] && !mode_pwm;
  wire cnt_wr  = do_wr && (ap_addr == `T16_OFS_CNT_L);
  wire flags_wr = do_wr && (ap_addr == `T16_OFS_FLAGS);
  assign hreadyout = !rd_pend;
  assign hresp     = 1'b0;

  // output compare level after an event
  function oc_next;
    input       cur;
    input [1:0] com;
    input       hit;
    input       frc;
    input       is_a;
    begin
      oc_next = cur;
      if (!mode_pwm) begin
        if (hit || frc) begin
          case (com)
            `T16_COM_TOGGLE: oc_next = !cur;
            `T16_COM_CLEAR:  oc_next = 1'b0;
            `T16_COM_SET:    oc_next = 1'b1;
            default:         oc_next = cur;
          endcase
        end
      end else if (com == `T16_COM_TOGGLE) begin
        if (hit && is_a && waveform_mode[3])
          oc_next = !cur;
      end else if (com[1]) begin
        if (mode_fast) begin
          if (tick && at_top)
            oc_next = !com[0];
          else if (hit)
            oc_next = com[0];
        end else if (hit) begin
          oc_next = count_up ? com[0] : !com[0];
        end
      end
    end
  endfunction

  // pin inputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      capt_sync  <= 2'h0;
      ext_sync   <= 2'h0;
      ext_prev   <= 1'b0;
      filt_shift <= 4'h0;
      filt_out   <= 1'b0;
      capt_prev  <= 1'b0;
      prescale   <= 10'h000;
    end else begin
      capt_sync  <= {capt_sync[0], capture_pin};
      ext_sync   <= {ext_sync[0], external_clock_pin};
      ext_prev   <= ext_sync[1];
      // the filter output moves on the edge that brings the fourth equal
      // sample, so it lags the plain synced input by exactly four cycles
      filt_shift <= next_filt_shift;
      if (next_filt_shift == 4'hF)
        filt_out <= 1'b1;
      else if (next_filt_shift == 4'h0)
        filt_out <= 1'b0;
      capt_prev  <= capt_sig;
      prescale   <= prescale + 10'h001;
    end
  end

  // bus phases
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_write <= 1'b0;
      ap_addr  <= 8'h00;
      rd_pend  <= 1'b0;
      wr_pend  <= 1'b0;
    end else begin
      rd_pend <= ap_take && !hwrite;
      wr_pend <= ap_take && hwrite;
      if (ap_take) begin
        ap_write <= hwrite;
        ap_addr  <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
      end
    end
  end

  // registers, counter, flags and outputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      timer_ctrl_a            <= `T16_RST_BYTE;
      timer_ctrl_b            <= `T16_RST_BYTE;
      timer_ctrl_d_pin_enable <= `T16_RST_BYTE;
      counter_value           <= `T16_RST_WORD;
      compare_a_value         <= `T16_RST_WORD;
      compare_b_value         <= `T16_RST_WORD;
      capture_value           <= `T16_RST_WORD;
      timer_irq_mask          <= `T16_RST_BYTE;
      timer_irq_flags         <= `T16_RST_BYTE;
      temp_high               <= `T16_RST_BYTE;
      count_up                <= 1'b1;
      match_block             <= 1'b0;
      oc_a                    <= 1'b0;
      oc_b                    <= 1'b0;
      hrdata                  <= 32'h00000000;
    end else begin
      // counter
      if (cnt_wr) begin
        counter_value <= {temp_high, wbyte};
        match_block   <= 1'b1;
      end else if (tick) begin
        match_block <= 1'b0;
        if (mode_phase) begin
          if (count_up && at_top) begin
            count_up      <= 1'b0;
            counter_value <= counter_value - 16'h0001;
          end else if (!count_up && at_zero) begin
            count_up      <= 1'b1;
            counter_value <= counter_value + 16'h0001;
          end else if (count_up) begin
            counter_value <= counter_value + 16'h0001;
          end else begin
            counter_value <= counter_value - 16'h0001;
          end
        end else if ((mode_ctc || mode_fast) && at_top) begin
          counter_value <= `T16_RST_WORD;
        end else begin
          counter_value <= counter_value + 16'h0001;
        end
      end
      if (!mode_phase)
        count_up <= 1'b1;
      // waveform outputs; a force only moves the level
      oc_a <= oc_next(oc_a, com_a, hit_a, force_a, 1'b1);
      oc_b <= oc_next(oc_b, com_b, hit_b, force_b, 1'b0);
      // capture
      if (capt_evt)
        capture_value <= counter_value;
      // flags: clear by vector or written one, set wins
      timer_irq_flags[`T16_BIT_CAPT] <= capt_flag_set ||
        (timer_irq_flags[`T16_BIT_CAPT] && !irq_vector_taken[3] &&
         !(flags_wr && wbyte[`T16_BIT_CAPT]));
      timer_irq_flags[`T16_BIT_CMPB] <= hit_b ||
        (timer_irq_flags[`T16_BIT_CMPB] && !irq_vector_taken[2] &&
         !(flags_wr && wbyte[`T16_BIT_CMPB]));
      timer_irq_flags[`T16_BIT_CMPA] <= hit_a ||
        (timer_irq_flags[`T16_BIT_CMPA] && !irq_vector_taken[1] &&
         !(flags_wr && wbyte[`T16_BIT_CMPA]));
      timer_irq_flags[`T16_BIT_OVF] <= ovf_evt ||
        (timer_irq_flags[`T16_BIT_OVF] && !irq_vector_taken[0] &&
         !(flags_wr && wbyte[`T16_BIT_OVF]));
      // register writes
      // high bytes only park in the shared temporary byte; the low byte write
      // moves all sixteen bits at once, so software must write high first
      if (do_wr) begin
        case (ap_addr)
          `T16_OFS_CTRL_A: timer_ctrl_a <= wbyte & 8'hF3;
          `T16_OFS_CTRL_B: timer_ctrl_b <= wbyte & `T16_CTRL_B_RMASK;
          `T16_OFS_CTRL_D: timer_ctrl_d_pin_enable <= wbyte;
          `T16_OFS_CNT_H, `T16_OFS_CMPA_H, `T16_OFS_CMPB_H, `T16_OFS_CAPT_H:
            temp_high <= wbyte;
          `T16_OFS_CMPA_L: compare_a_value <= {temp_high, wbyte};
          `T16_OFS_CMPB_L: compare_b_value <= {temp_high, wbyte};
          `T16_OFS_CAPT_L: if (!capt_evt) capture_value <= {temp_high, wbyte};
          `T16_OFS_MASK:   timer_irq_mask <= wbyte & `T16_MASK_RMASK;
          default: ;
        endcase
      end
      // register reads; counter and capture low byte reads latch the high byte
      // a counter or capture high read returns that latched byte, not the live one
      if (do_rd) begin
        case (ap_addr)
          `T16_OFS_CTRL_A: hrdata <= {24'h000000, timer_ctrl_a};
          `T16_OFS_CTRL_B: hrdata <= {24'h000000, timer_ctrl_b};
          `T16_OFS_CTRL_C: hrdata <= 32'h00000000;
          `T16_OFS_CTRL_D: hrdata <= {24'h000000, timer_ctrl_d_pin_enable};
          `T16_OFS_CNT_L: begin
            hrdata    <= {24'h000000, counter_value[7:0]};
            temp_high <= counter_value[15:8];
          end
          `T16_OFS_CAPT_L: begin
            hrdata    <= {24'h000000, capture_value[7:0]};
            temp_high <= capture_value[15:8];
          end
          `T16_OFS_CMPA_L: hrdata <= {24'h000000, compare_a_value[7:0]};
          `T16_OFS_CMPA_H: hrdata <= {24'h000000, compare_a_value[15:8]};
          `T16_OFS_CMPB_L: hrdata <= {24'h000000, compare_b_value[7:0]};
          `T16_OFS_CMPB_H: hrdata <= {24'h000000, compare_b_value[15:8]};
          `T16_OFS_CNT_H, `T16_OFS_CAPT_H: hrdata <= {24'h000000, temp_high};
          `T16_OFS_MASK:  hrdata <= {24'h000000, timer_irq_mask};
          `T16_OFS_FLAGS: hrdata <= {24'h000000, timer_irq_flags};
          default:        hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  // interrupt requests follow flag and enable levels
  assign irq_capture   = global_irq_en && timer_irq_mask[`T16_BIT_CAPT] && timer_irq_flags[`T16_BIT_CAPT];
  assign irq_compare_b = global_irq_en && timer_irq_mask[`T16_BIT_CMPB] && timer_irq_flags[`T16_BIT_CMPB];
  assign irq_compare_a = global_irq_en && timer_irq_mask[`T16_BIT_CMPA] && timer_irq_flags[`T16_BIT_CMPA];
  assign irq_overflow  = global_irq_en && timer_irq_mask[`T16_BIT_OVF] && timer_irq_flags[`T16_BIT_OVF];

  // pins driven only where enabled and a compare output mode is chosen
  assign chan_a_pins      = {4{oc_a}};
  assign chan_b_pins      = {4{oc_b}};
  assign chan_a_pins_oe_n = ~(chan_a_pin_enables & {4{com_a != `T16_COM_OFF}});
  assign chan_b_pins_oe_n = ~(chan_b_pin_enables & {4{com_b != `T16_COM_OFF}});

endmodule // t16_timer

// File: bench/t16_checker.sv
// bus, register and interrupt port assertions for the 16-bit timer
`timescale 1ns/1ns
module t16_checker (
  input wire        hclk,             // clock
  input wire        hresetn,          // reset, active low
  input wire        hsel,             // slave select
  input wire [31:0] haddr,            // byte address
  input wire [1:0]  htrans,           // transfer type
  input wire        hwrite,           // write when high
  input wire        hready,           // bus ready
  input wire [31:0] hrdata,           // read data
  input wire        hreadyout,        // slave ready
  input wire        hresp,            // response
  input wire        global_irq_en,    // global enable
  input wire        irq_capture,      // capture request
  input wire        irq_compare_b,    // compare b request
  input wire        irq_compare_a,    // compare a request
  input wire        irq_overflow,     // overflow request
  input wire [3:0]  chan_a_pins_oe_n  // channel a drive
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire take = hsel && hready && htrans[1];
  wire any_irq = irq_capture || irq_compare_b || irq_compare_a || irq_overflow;
  // reads of a register: masked bits are zero in the data phase
  property p_rd_zero(a, m);
    (take && !hwrite && haddr == {24'h000000, a}) |-> ##2 (hrdata[7:0] & m) == 8'h00;
  endproperty
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_no_wait: assert property (take && hwrite |=> hreadyout)
    else $error("write inserted a wait state");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_rdata_upper: assert property (take && !hwrite |-> ##2 hrdata[31:8] == 24'h000000)
    else $error("upper read data not zero");
  a_force_reads_zero: assert property (p_rd_zero(8'h08, 8'hFF))
    else $error("force register read nonzero");
  a_ctrl_reserved: assert property (p_rd_zero(8'h04, 8'h20))
    else $error("reserved control bit read nonzero");
  a_mask_reserved: assert property (p_rd_zero(8'h30, 8'hD8))
    else $error("reserved mask bits read nonzero");
  a_flag_reserved: assert property (p_rd_zero(8'h34, 8'hD8))
    else $error("reserved flag bits read nonzero");
  a_irq_global: assert property (any_irq |-> global_irq_en)
    else $error("request without global enable");
  a_irq_drops: assert property ($fell(global_irq_en) |-> !any_irq)
    else $error("request stayed after global disable");
  c_capture: cover property (irq_capture);
  c_overflow: cover property (irq_overflow);
  c_pin_drive: cover property (chan_a_pins_oe_n != 4'hF);
endmodule // t16_checker
bind t16_timer t16_checker i_t16_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .global_irq_en(global_irq_en), .irq_capture(irq_capture), .irq_compare_b(irq_compare_b),
  .irq_compare_a(irq_compare_a), .irq_overflow(irq_overflow), .chan_a_pins_oe_n(chan_a_pins_oe_n));

// File: bench/t16_timer_tb.sv
// self-checking bench for the 16-bit timer register block
`timescale 1ns/1ns
`include "t16_defs.vh"
`define CHK(g, e) begin check_count = check_count + 1; if ((g) !== (e)) begin n_errors = n_errors + 1; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module t16_timer_tb;
  reg         hclk, hresetn, hsel, hwrite, capture_pin, external_clock_pin, global_irq_en;
  reg  [31:0] haddr, hwdata;
  reg  [1:0]  htrans;
  reg  [3:0]  irq_vector_taken;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, irq_capture, irq_compare_b, irq_compare_a, irq_overflow;
  wire [3:0]  chan_a_pins, chan_a_pins_oe_n, chan_b_pins, chan_b_pins_oe_n;
  integer     n_errors, check_count, n0, n1, n2;
  reg  [15:0] c;
  t16_timer i_t16_timer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .capture_pin(capture_pin), .external_clock_pin(external_clock_pin),
    .global_irq_en(global_irq_en), .irq_vector_taken(irq_vector_taken), .irq_capture(irq_capture),
    .irq_compare_b(irq_compare_b), .irq_compare_a(irq_compare_a), .irq_overflow(irq_overflow),
    .chan_a_pins(chan_a_pins), .chan_a_pins_oe_n(chan_a_pins_oe_n), .chan_b_pins(chan_b_pins),
    .chan_b_pins_oe_n(chan_b_pins_oe_n));
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  task step(input integer n);
    repeat (n) @(posedge hclk);
  endtask
  // one single transfer; entered and left just after a rising edge
  task bus(input w, input [7:0] a, input [7:0] d, output [7:0] q);
    begin
      hsel <= 1'b1; haddr <= {24'h000000, a}; htrans <= 2'b10; hwrite <= w;
      @(posedge hclk); while (!hreadyout) @(posedge hclk);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= {24'h000000, d};
      @(posedge hclk); while (!hreadyout) @(posedge hclk);
      q = hrdata[7:0];
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task rd(input [7:0] a, input [7:0] e);
    reg [7:0] q;
    begin bus(1'b0, a, 8'h00, q); `CHK(q, e) end
  endtask
  task wr16(input [7:0] a, input [15:0] v);
    begin wr(a + 8'h04, v[15:8]); wr(a, v[7:0]); end
  endtask
  task rd16(input [7:0] a, input [15:0] e);
    begin rd(a, e[7:0]); rd(a + 8'h04, e[15:8]); end
  endtask
  task rdcnt(output [15:0] v);
    begin bus(1'b0, `T16_OFS_CNT_L, 8'h00, v[7:0]); bus(1'b0, `T16_OFS_CNT_H, 8'h00, v[15:8]); end
  endtask
  task vec(input [3:0] m);
    begin irq_vector_taken <= m; step(1); irq_vector_taken <= 4'h0; step(1); end
  endtask
  task t_regs;
    reg [23:0] tbl [0:5];
    integer i;
    begin
      tbl = '{24'h04FFDF, 24'h08C000, 24'h0C5A5A, 24'h30FF27, 24'h34FF00, 24'h3CFF00};
      for (i = 0; i < 6; i = i + 1) begin
        rd(tbl[i][23:16], 8'h00);
        wr(tbl[i][23:16], tbl[i][15:8]);
        rd(tbl[i][23:16], tbl[i][7:0]);
      end
      wr(`T16_OFS_CTRL_B, 8'h00); wr(`T16_OFS_MASK, 8'h00);
      wr16(`T16_OFS_CNT_L, 16'h1234);
      rd16(`T16_OFS_CNT_L, 16'h1234);
      wr(`T16_OFS_CMPA_H, 8'hAB); wr(`T16_OFS_CMPB_L, 8'hCD);
      rd16(`T16_OFS_CMPB_L, 16'hABCD);
      $display("test regs done");
    end
  endtask
  task t_compare;
    begin
      global_irq_en <= 1'b0;
      wr16(`T16_OFS_CMPA_L, 16'h0010); wr16(`T16_OFS_CNT_L, 16'h0000); wr(`T16_OFS_MASK, 8'h02);
      wr(`T16_OFS_CTRL_B, 8'h01); step(30); wr(`T16_OFS_CTRL_B, 8'h00);
      `CHK(irq_compare_a, 1'b0)
      rd(`T16_OFS_FLAGS, 8'h02);
      global_irq_en <= 1'b1; step(1);
      `CHK(irq_compare_a, 1'b1)
      vec(4'h2);
      `CHK(irq_compare_a, 1'b0)
      wr16(`T16_OFS_CMPB_L, 16'h0050); wr16(`T16_OFS_CNT_L, 16'h0050);
      wr(`T16_OFS_CTRL_B, 8'h01); step(5); wr(`T16_OFS_CTRL_B, 8'h00);
      rd(`T16_OFS_FLAGS, 8'h00);
      wr16(`T16_OFS_CNT_L, 16'hFFF0); wr(`T16_OFS_MASK, 8'h01);
      wr(`T16_OFS_CTRL_B, 8'h01); step(20); wr(`T16_OFS_CTRL_B, 8'h00);
      `CHK(irq_overflow, 1'b1)
      wr(`T16_OFS_FLAGS, 8'h00); rd(`T16_OFS_FLAGS, 8'h01);
      wr(`T16_OFS_FLAGS, 8'h01); rd(`T16_OFS_FLAGS, 8'h00);
      $display("test compare done");
    end
  endtask
  task t_force;
    reg [23:0] tbl [0:5];
    integer i;
    begin
      tbl = '{24'h4080F0, 24'h408000, 24'hC080F0, 24'h808000, 24'h10400F, 24'hC1800F};
      wr(`T16_OFS_MASK, 8'h02); wr(`T16_OFS_CTRL_D, 8'h5A);
      for (i = 0; i < 6; i = i + 1) begin
        wr(`T16_OFS_CTRL_A, tbl[i][23:16]); wr(`T16_OFS_CTRL_C, tbl[i][15:8]); step(2);
        `CHK(chan_a_pins, tbl[i][7:4])
        `CHK(chan_b_pins, tbl[i][3:0])
        `CHK(chan_a_pins_oe_n, (tbl[i][23:22] != 2'b00) ? 4'h5 : 4'hF)
        `CHK(chan_b_pins_oe_n, (tbl[i][21:20] != 2'b00) ? 4'hA : 4'hF)
      end
      `CHK(irq_compare_a, 1'b0)
      rd(`T16_OFS_FLAGS, 8'h00);
      wr(`T16_OFS_CTRL_A, 8'h00);
      $display("test force done");
    end
  endtask
  // time in clocks from a capture pin change to the capture request
  task lat(input v, output integer n);
    begin
      capture_pin <= v; n = 0; step(1);
      while (irq_capture !== 1'b1 && n < 40) begin n = n + 1; step(1); end
      vec(4'h8);
    end
  endtask
  task t_capture;
    begin
      wr(`T16_OFS_MASK, 8'h20); wr16(`T16_OFS_CNT_L, 16'h1234);
      lat(1'b0, n0);
      `CHK(n0 < 40, 1'b1)
      rd16(`T16_OFS_CAPT_L, 16'h1234);
      capture_pin <= 1'b1; step(12);
      `CHK(irq_capture, 1'b0)
      wr(`T16_OFS_CTRL_B, 8'h40); capture_pin <= 1'b0; step(12);
      `CHK(irq_capture, 1'b0)
      lat(1'b1, n1);
      `CHK(n1, n0)
      wr(`T16_OFS_CTRL_B, 8'h80); capture_pin <= 1'b0; step(2); capture_pin <= 1'b1; step(12);
      `CHK(irq_capture, 1'b0)
      lat(1'b0, n2);
      `CHK(n2, n0 + 4)
      wr(`T16_OFS_CTRL_B, 8'h18); capture_pin <= 1'b1; step(12); capture_pin <= 1'b0; step(12);
      `CHK(irq_capture, 1'b0)
      wr16(`T16_OFS_CAPT_L, 16'h1240); wr(`T16_OFS_CTRL_B, 8'h19); step(20); wr(`T16_OFS_CTRL_B, 8'h00);
      `CHK(irq_capture, 1'b1)
      vec(4'h8);
      $display("test capture done");
    end
  endtask
  task pulse(input integer n);
    repeat (n) begin external_clock_pin <= 1'b1; step(4); external_clock_pin <= 1'b0; step(4); end
  endtask
  task t_clocks;
    integer k;
    integer dv [0:4];
    begin
      dv = '{1, 8, 64, 256, 1024};
      wr(`T16_OFS_MASK, 8'h00);
      for (k = 0; k < 5; k = k + 1) begin
        wr16(`T16_OFS_CNT_L, 16'h0000); wr(`T16_OFS_CTRL_B, k + 1); step(4 * dv[k] - 2);
        wr(`T16_OFS_CTRL_B, 8'h00); rdcnt(c);
        `CHK(c >= 16'd3 && c <= 16'd6, 1'b1)
      end
      wr16(`T16_OFS_CNT_L, 16'h0000); wr(`T16_OFS_CTRL_B, 8'h07); pulse(5); rdcnt(c);
      `CHK(c, 16'h0005)
      wr(`T16_OFS_CTRL_B, 8'h06); pulse(3); wr(`T16_OFS_CTRL_B, 8'h00); rdcnt(c);
      `CHK(c, 16'h0008)
      $display("test clocks done");
    end
  endtask
  task test_done;
    begin
      $display("checks %0d, mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
    end
  endtask
  initial begin
    #(40 * 40000);
    n_errors = n_errors + 1;
    test_done;
  end
  initial begin
    n_errors = 0; check_count = 0; hresetn = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h00000000;
    hwdata = 32'h00000000; htrans = 2'b00; capture_pin = 1'b1; external_clock_pin = 1'b0;
    global_irq_en = 1'b1; irq_vector_taken = 4'h0;
    step(12); hresetn <= 1'b1; step(1);
    t_regs; t_compare; t_force; t_capture; t_clocks;
    test_done;
  end
endmodule // t16_timer_tb
